/* swa_pkg.sv */
// constants, types and register map of the sysref window and autocal block
package swa_pkg;

  localparam int SWA_MAP_W = 24;
  localparam int SWA_CHOICE_W = 4;
  localparam int SWA_ADDR_W = 12;
  localparam int SWA_DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0] SWA_IDX_CLK_CTRL = 8'h29;
  localparam logic [7:0] SWA_IDX_CAL_GO = 8'h2A;
  localparam logic [7:0] SWA_IDX_CAL_SETUP = 8'h2B;
  localparam logic [7:0] SWA_IDX_MAP_LOW = 8'h2C;
  localparam logic [7:0] SWA_IDX_MAP_MID = 8'h2D;
  localparam logic [7:0] SWA_IDX_MAP_TOP = 8'h2E;
  localparam logic [7:0] SWA_IDX_CAL_STAT = 8'h2F;
  localparam logic [7:0] SWA_IDX_DELAY = 8'h30;

  // field positions
  localparam int SWA_CHOICE_LSB = 0;
  localparam int SWA_FINE_STEP_BIT = 4;
  localparam int SWA_GO_BIT = 0;
  localparam int SWA_SETTLE_LSB = 0;
  localparam int SWA_STAT_DONE_BIT = 0;
  localparam int SWA_STAT_VALID_BIT = 1;
  localparam int SWA_STAT_BUSY_BIT = 2;
  localparam int SWA_STAT_RESULT_LSB = 8;
  localparam int SWA_DELAY_FINE_LSB = 0;
  localparam int SWA_DELAY_COARSE_LSB = 8;
  localparam int SWA_DELAY_INV_BIT = 16;

  // reset values and counts
  localparam logic [SWA_CHOICE_W-1:0] SWA_CHOICE_RESET = 4'h0;
  localparam logic SWA_FINE_STEP_RESET = 1'b0;
  localparam logic [7:0] SWA_SETTLE_RESET = 8'h10;
  localparam logic [1:0] SWA_EDGES_FOR_VALID = 2'h3;
  localparam logic [7:0] SWA_COARSE_MAX = 8'hFF;
  localparam logic [SWA_MAP_W-1:0] SWA_MAP_ENDS = 24'h800001;

  typedef struct packed {
    logic inv;
    logic [7:0] coarse;
    logic [7:0] fine;
  } swa_delay_t;

  localparam swa_delay_t SWA_DELAY_RESET = '{inv: 1'b0, coarse: 8'h00, fine: 8'h00};

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [SWA_ADDR_W-1:0] paddr;
    logic [SWA_DATA_W-1:0] pwdata;
  } swa_apb_req_t;

  typedef enum logic [2:0] {
    CAL_IDLE,
    CAL_SETTLE,
    CAL_WAIT_EDGE,
    CAL_CHECK,
    CAL_DONE
  } swa_cal_state_t;

endpackage : swa_pkg

/* swa_phase_map.sv */
// sysref position detector: builds the 24-bit unsafe-position map
`timescale 1ns/10ps
`default_nettype none
module swa_phase_map (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // sysref and detector flags
  input wire logic sysref,
  input wire logic [swa_pkg::SWA_MAP_W-1:0] tap_hazard,
  input wire logic restart,
  // map out
  output logic [swa_pkg::SWA_MAP_W-1:0] map,
  output logic map_valid
);
  import swa_pkg::*;

  logic sysref_q;
  logic [1:0] edge_count;
  logic rise;

  assign rise = sysref & ~sysref_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= sysref;
    end
  end

  // saturating count of sysref rises since last restart
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      edge_count <= 2'h0;
    end else if (restart) begin
      edge_count <= 2'h0;
    end else if (rise && edge_count != SWA_EDGES_FOR_VALID) begin
      edge_count <= edge_count + 2'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      map_valid <= 1'b0;
    end else begin
      map_valid <= !restart && (edge_count == SWA_EDGES_FOR_VALID);
    end
  end

  // sticky hazard per position; the two ends cannot be judged
  genvar i;
  generate
    for (i = 0; i < SWA_MAP_W; i = i + 1) begin : g_pos
      if (i == 0 || i == SWA_MAP_W - 1) begin : g_end
        always_ff @(posedge clock or posedge rst) begin
          if (rst) begin
            map[i] <= 1'b1;
          end else begin
            map[i] <= 1'b1;
          end
        end
      end else begin : g_mid
        always_ff @(posedge clock or posedge rst) begin
          if (rst) begin
            map[i] <= 1'b0;
          end else if (restart) begin
            map[i] <= 1'b0;
          end else if (tap_hazard[i]) begin
            map[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule : swa_phase_map
`default_nettype wire

/* swa_top.sv */
// sysref window control and automatic sysref calibration, apb slave
`timescale 1ns/10ps
`default_nettype none
module swa_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire swa_pkg::swa_apb_req_t apb_req,
  output logic [swa_pkg::SWA_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // sysref and analog detector
  input wire logic sysref,
  input wire logic [swa_pkg::SWA_MAP_W-1:0] sysref_taps,
  input wire logic [swa_pkg::SWA_MAP_W-1:0] tap_hazard,
  input wire logic edge_aligned,
  // controls to clock path
  output logic [swa_pkg::SWA_CHOICE_W-1:0] capture_phase_choice,
  output logic phase_step_fine,
  output swa_pkg::swa_delay_t aperture_delay_setting,
  output logic sysref_capture
);
  import swa_pkg::*;

  // bus decode
  logic [7:0] idx;
  logic access;
  logic wr_ok;
  logic mapped;

  // software state
  logic autocal_go;
  logic [7:0] autocal_setup;
  logic autocal_finished;
  swa_delay_t autocal_result_delay;

  // search state
  swa_cal_state_t state;
  swa_cal_state_t next_state;
  logic [7:0] settle_count;
  logic sysref_q;
  logic sysref_rise;
  logic found0;
  logic [7:0] best0;
  logic start_cal;
  logic stop_cal;
  logic step_hit;
  logic step_end;

  // phase map
  logic [SWA_MAP_W-1:0] capture_phase_map;
  logic map_valid;
  logic map_restart;

  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i == SWA_IDX_CLK_CTRL) || (i == SWA_IDX_CAL_GO) ||
                (i == SWA_IDX_CAL_SETUP) || (i == SWA_IDX_MAP_LOW) ||
                (i == SWA_IDX_MAP_MID) || (i == SWA_IDX_MAP_TOP) ||
                (i == SWA_IDX_CAL_STAT) || (i == SWA_IDX_DELAY);
  endfunction : is_mapped

  function automatic logic wr_to(input logic ok, input logic [7:0] i, input logic [7:0] r);
    wr_to = ok && (i == r);
  endfunction : wr_to

  assign idx = apb_req.paddr[9:2];
  assign mapped = is_mapped(idx) && (apb_req.paddr[SWA_ADDR_W-1:10] == 2'h0);
  assign access = apb_req.psel && apb_req.penable;
  // write lands only at the completing edge
  assign wr_ok = access && pready && apb_req.pwrite && mapped;

  assign start_cal = wr_to(wr_ok, idx, SWA_IDX_CAL_GO) &&
                     apb_req.pwdata[SWA_GO_BIT] && !autocal_go;
  assign stop_cal = wr_to(wr_ok, idx, SWA_IDX_CAL_GO) && !apb_req.pwdata[SWA_GO_BIT];
  assign sysref_rise = sysref & ~sysref_q;
  assign step_hit = edge_aligned;
  assign step_end = aperture_delay_setting.coarse == SWA_COARSE_MAX;
  // changing the step size invalidates the collected map
  assign map_restart = wr_to(wr_ok, idx, SWA_IDX_CLK_CTRL) &&
                       (apb_req.pwdata[SWA_FINE_STEP_BIT] != phase_step_fine);

  swa_phase_map u_map (
    .clock(clock),
    .rst(rst),
    .sysref(sysref),
    .tap_hazard(tap_hazard),
    .restart(map_restart),
    .map(capture_phase_map),
    .map_valid(map_valid)
  );

  // apb answer: one wait cycle so read data leaves a flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (access && !pready && !apb_req.pwrite) begin
      prdata <= '0;
      case (idx)
        SWA_IDX_CLK_CTRL: begin
          prdata[SWA_CHOICE_LSB +: SWA_CHOICE_W] <= capture_phase_choice;
          prdata[SWA_FINE_STEP_BIT] <= phase_step_fine;
        end
        SWA_IDX_CAL_GO: begin
          prdata[SWA_GO_BIT] <= autocal_go;
        end
        SWA_IDX_CAL_SETUP: begin
          prdata[SWA_SETTLE_LSB +: 8] <= autocal_setup;
        end
        SWA_IDX_MAP_LOW: begin
          prdata[7:0] <= capture_phase_map[7:0];
        end
        SWA_IDX_MAP_MID: begin
          prdata[7:0] <= capture_phase_map[15:8];
        end
        SWA_IDX_MAP_TOP: begin
          prdata[7:0] <= capture_phase_map[23:16];
        end
        SWA_IDX_CAL_STAT: begin
          prdata[SWA_STAT_DONE_BIT] <= autocal_finished;
          prdata[SWA_STAT_VALID_BIT] <= map_valid;
          prdata[SWA_STAT_BUSY_BIT] <= (state != CAL_IDLE) && (state != CAL_DONE);
          prdata[SWA_STAT_RESULT_LSB +: $bits(swa_delay_t)] <= autocal_result_delay;
        end
        SWA_IDX_DELAY: begin
          prdata[SWA_DELAY_FINE_LSB +: 8] <= aperture_delay_setting.fine;
          prdata[SWA_DELAY_COARSE_LSB +: 8] <= aperture_delay_setting.coarse;
          prdata[SWA_DELAY_INV_BIT] <= aperture_delay_setting.inv;
        end
        default: begin
          prdata <= '0;
        end
      endcase
    end
  end

  // clock control: only four bits, so positions 16 to 23 cannot be chosen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capture_phase_choice <= SWA_CHOICE_RESET;
      phase_step_fine <= SWA_FINE_STEP_RESET;
    end else if (wr_to(wr_ok, idx, SWA_IDX_CLK_CTRL)) begin
      capture_phase_choice <= apb_req.pwdata[SWA_CHOICE_LSB +: SWA_CHOICE_W];
      phase_step_fine <= apb_req.pwdata[SWA_FINE_STEP_BIT];
    end
  end

  // capture sysref at the chosen candidate position
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sysref_capture <= 1'b0;
    end else begin
      sysref_capture <= sysref_taps[capture_phase_choice];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      autocal_setup <= SWA_SETTLE_RESET;
    end else if (wr_to(wr_ok, idx, SWA_IDX_CAL_SETUP)) begin
      autocal_setup <= apb_req.pwdata[SWA_SETTLE_LSB +: 8];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      autocal_go <= 1'b0;
    end else if (wr_to(wr_ok, idx, SWA_IDX_CAL_GO)) begin
      autocal_go <= apb_req.pwdata[SWA_GO_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= sysref;
    end
  end

  // search sequencing
  always_comb begin
    next_state = state;
    case (state)
      CAL_IDLE: begin
        if (start_cal) begin
          next_state = CAL_SETTLE;
        end
      end
      CAL_SETTLE: begin
        if (settle_count == 8'h00) begin
          next_state = CAL_WAIT_EDGE;
        end
      end
      CAL_WAIT_EDGE: begin
        // relies on sysref running periodically
        if (sysref_rise) begin
          next_state = CAL_CHECK;
        end
      end
      CAL_CHECK: begin
        if ((step_hit || step_end) && aperture_delay_setting.inv) begin
          next_state = CAL_DONE;
        end else begin
          next_state = CAL_SETTLE;
        end
      end
      CAL_DONE: begin
        if (start_cal) begin
          next_state = CAL_SETTLE;
        end
      end
      default: begin
        next_state = CAL_IDLE;
      end
    endcase
    if (stop_cal) begin
      next_state = CAL_IDLE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= CAL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // each new delay is given the programmed settle time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settle_count <= 8'h00;
    end else if (next_state == CAL_SETTLE && state != CAL_SETTLE) begin
      settle_count <= autocal_setup;
    end else if (state == CAL_SETTLE && settle_count != 8'h00) begin
      settle_count <= settle_count - 8'h01;
    end
  end

  // result of the non-inverted pass
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      found0 <= 1'b0;
      best0 <= SWA_COARSE_MAX;
    end else if (start_cal) begin
      found0 <= 1'b0;
      best0 <= SWA_COARSE_MAX;
    end else if (state == CAL_CHECK && !aperture_delay_setting.inv && step_hit) begin
      found0 <= 1'b1;
      best0 <= aperture_delay_setting.coarse;
    end
  end

  // delay applied to the clock path: search owns it while running
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aperture_delay_setting <= SWA_DELAY_RESET;
    end else if (start_cal) begin
      aperture_delay_setting <= SWA_DELAY_RESET;
    end else if (state == CAL_CHECK) begin
      if (!aperture_delay_setting.inv) begin
        if (step_hit || step_end) begin
          aperture_delay_setting.inv <= 1'b1;
          aperture_delay_setting.coarse <= 8'h00;
        end else begin
          aperture_delay_setting.coarse <= aperture_delay_setting.coarse + 8'h01;
        end
      end else if (step_hit || step_end) begin
        // keep the polarity needing less coarse delay, less clock path loss
        if (found0 && (!step_hit || best0 <= aperture_delay_setting.coarse)) begin
          aperture_delay_setting.inv <= 1'b0;
          aperture_delay_setting.coarse <= best0;
        end
      end else begin
        aperture_delay_setting.coarse <= aperture_delay_setting.coarse + 8'h01;
      end
    end else if (wr_to(wr_ok, idx, SWA_IDX_DELAY) &&
                 (state == CAL_IDLE || state == CAL_DONE)) begin
      aperture_delay_setting.fine <= apb_req.pwdata[SWA_DELAY_FINE_LSB +: 8];
      aperture_delay_setting.coarse <= apb_req.pwdata[SWA_DELAY_COARSE_LSB +: 8];
      aperture_delay_setting.inv <= apb_req.pwdata[SWA_DELAY_INV_BIT];
    end
    // otherwise the last setting is held indefinitely
  end

  // latched copy of the search outcome
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      autocal_result_delay <= SWA_DELAY_RESET;
    end else if (state == CAL_CHECK && aperture_delay_setting.inv && (step_hit || step_end)) begin
      autocal_result_delay.fine <= aperture_delay_setting.fine;
      if (found0 && (!step_hit || best0 <= aperture_delay_setting.coarse)) begin
        autocal_result_delay.inv <= 1'b0;
        autocal_result_delay.coarse <= best0;
      end else begin
        autocal_result_delay.inv <= 1'b1;
        autocal_result_delay.coarse <= aperture_delay_setting.coarse;
      end
    end
  end

  // completion flag: start clears, search end sets; they never coincide
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      autocal_finished <= 1'b0;
    end else if (start_cal) begin
      autocal_finished <= 1'b0;
    end else if (state == CAL_CHECK && next_state == CAL_DONE) begin
      autocal_finished <= 1'b1;
    end
  end

endmodule : swa_top
`default_nettype wire

/* swa_checker.sv */
// port-level assertions for the sysref window and autocal block
`timescale 1ns/10ps
`default_nettype none
module swa_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb
  input wire swa_pkg::swa_apb_req_t apb_req,
  input wire logic [swa_pkg::SWA_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // clock path
  input wire logic [swa_pkg::SWA_MAP_W-1:0] sysref_taps,
  input wire logic [swa_pkg::SWA_CHOICE_W-1:0] capture_phase_choice,
  input wire logic phase_step_fine,
  input wire swa_pkg::swa_delay_t aperture_delay_setting,
  input wire logic sysref_capture
);
  import swa_pkg::*;
  logic [7:0] idx;
  logic done_rd;
  logic done_wr;
  assign idx = apb_req.paddr[9:2];
  assign done_rd = pready && apb_req.psel && apb_req.penable && !apb_req.pwrite
    && apb_req.paddr[11:10] == 2'h0;
  assign done_wr = pready && apb_req.psel && apb_req.penable && apb_req.pwrite
    && apb_req.paddr[11:10] == 2'h0;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_capture_at_choice: assert property (
    !$past(rst) |-> sysref_capture == $past(sysref_taps[capture_phase_choice]))
    else $error("capture bit differs from chosen tap");
  a_ready_timing: assert property (
    apb_req.psel && !apb_req.penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (pready && (apb_req.paddr[11:10] != 2'h0
    || idx < SWA_IDX_CLK_CTRL || idx > SWA_IDX_DELAY) |-> pslverr
    && (apb_req.pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_map_ends_set: assert property (
    done_rd && (idx == SWA_IDX_MAP_LOW || idx == SWA_IDX_MAP_TOP) |-> prdata[31:8] == 24'h0
    && (prdata[0] || idx == SWA_IDX_MAP_TOP) && (prdata[7] || idx == SWA_IDX_MAP_LOW))
    else $error("map end bit reads safe");
  a_ctrl_write_applies: assert property (
    done_wr && idx == SWA_IDX_CLK_CTRL |=> capture_phase_choice == $past(apb_req.pwdata[3:0])
    && phase_step_fine == $past(apb_req.pwdata[4]))
    else $error("clock control write not applied");
  a_result_applied: assert property (
    done_rd && idx == SWA_IDX_CAL_STAT && prdata[0] |-> prdata[24:8] == aperture_delay_setting)
    else $error("result field differs from applied delay");
  a_busy_not_done: assert property (
    done_rd && idx == SWA_IDX_CAL_STAT && prdata[2] |-> !prdata[0])
    else $error("finished flag high while search busy");
  c_search_done: cover property (done_rd && idx == SWA_IDX_CAL_STAT && prdata[0]);
  c_refused: cover property (pslverr);
  c_choice_top: cover property (capture_phase_choice == 4'hF);
endmodule : swa_checker
bind swa_top swa_checker i_swa_checker (
  .clock(clock), .rst(rst), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sysref_taps(sysref_taps), .capture_phase_choice(capture_phase_choice),
  .phase_step_fine(phase_step_fine), .aperture_delay_setting(aperture_delay_setting),
  .sysref_capture(sysref_capture)
);
`default_nettype wire

/* swa_src_model.sv */
// far-side model: periodic sysref source, tap sampler and phase comparator
`timescale 1ns/10ps
`default_nettype none
module swa_src_model #(
  parameter int PERIOD = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // scenario controls
  input wire logic [8:0] tgt0,
  input wire logic [8:0] tgt1,
  input wire logic [23:0] hz_mask,
  input wire logic [23:0] tap_pat,
  input wire swa_pkg::swa_delay_t delay,
  // towards the block
  output logic sysref,
  output logic [23:0] taps,
  output logic [23:0] hazard,
  output logic aligned
);
  import swa_pkg::*;
  logic [7:0] cnt;
  // free running, never paused during a search
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 8'h00;
      sysref <= 1'b0;
    end else begin
      cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
      sysref <= (cnt < 8'(PERIOD / 2));
    end
  end
  assign taps = sysref ? tap_pat : ~tap_pat;
  assign hazard = sysref ? hz_mask : 24'h000000;
  // bit 8 set in a target means that polarity never aligns
  assign aligned = delay.inv ? ({1'b0, delay.coarse} == tgt1) : ({1'b0, delay.coarse} == tgt0);
endmodule : swa_src_model
`default_nettype wire

/* tb_top.sv */
// self-checking testbench for the sysref window and autocal block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import swa_pkg::*;
  typedef struct packed {
    logic [8:0] t0;
    logic [8:0] t1;
    swa_delay_t res;
  } swa_row_t;
  logic clock;
  logic rst;
  swa_apb_req_t req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sysref;
  logic [23:0] taps;
  logic [23:0] hazard;
  logic aligned;
  logic [3:0] choice;
  logic fine_step;
  swa_delay_t delay;
  logic cap;
  logic [8:0] tgt0;
  logic [8:0] tgt1;
  logic [23:0] hz_mask;
  logic [23:0] tap_pat;
  logic [31:0] d;
  logic e;
  logic sp;
  int err_count = 0;
  int comparisons = 0;
  swa_row_t rows [6];
  swa_top i_swa_top (
    .clock(clock), .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sysref(sysref), .sysref_taps(taps), .tap_hazard(hazard),
    .edge_aligned(aligned), .capture_phase_choice(choice), .phase_step_fine(fine_step),
    .aperture_delay_setting(delay), .sysref_capture(cap)
  );
  swa_src_model i_swa_src_model (
    .clock(clock), .rst(rst), .tgt0(tgt0), .tgt1(tgt1), .hz_mask(hz_mask),
    .tap_pat(tap_pat), .delay(delay), .sysref(sysref), .taps(taps), .hazard(hazard),
    .aligned(aligned)
  );
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ba
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer; waits for pready without a bound, never assumes latency
  task automatic apb(input logic wr_en, input logic [11:0] addr, input logic [31:0] wd);
    @(posedge clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr_en, paddr: addr, pwdata: wd};
    @(posedge clock);
    req.penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    req <= '0;
  endtask : apb
  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    apb(1'b1, ba(i), v);
  endtask : wr
  task automatic rd(input logic [7:0] i);
    apb(1'b0, ba(i), 32'h0);
  endtask : rd
  task automatic poll();
    do begin
      rd(SWA_IDX_CAL_STAT);
    end while (d[0] !== 1'b1);
  endtask : poll
  task automatic end_sim();
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    end_sim();
  end
  initial begin
    // targets per polarity and the expected {inv, coarse, fine}
    rows[0] = '{9'h005, 9'h005, 17'h00500};
    rows[1] = '{9'h009, 9'h002, 17'h10200};
    rows[2] = '{9'h002, 9'h009, 17'h00200};
    rows[3] = '{9'h100, 9'h003, 17'h10300};
    rows[4] = '{9'h004, 9'h100, 17'h00400};
    rows[5] = '{9'h100, 9'h100, 17'h1FF00};
    rst <= 1'b1;
    req <= '0;
    tgt0 <= 9'h100;
    tgt1 <= 9'h100;
    hz_mask <= 24'h000000;
    tap_pat <= 24'h00A5A5;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd(SWA_IDX_CAL_STAT);
    chk(d, 32'h0);
    rd(SWA_IDX_CAL_SETUP);
    chk(d, 32'h10);
    hz_mask <= 24'h000100;
    repeat (40) @(posedge clock);
    hz_mask <= 24'h000000;
    rd(SWA_IDX_MAP_MID);
    chk(d, 32'h01);
    rd(SWA_IDX_MAP_TOP);
    chk(d, 32'h80);
    rd(SWA_IDX_CAL_STAT);
    chk(d, 32'h2);
    // a step change restarts the map, so validity drops again
    wr(SWA_IDX_CLK_CTRL, 32'h10);
    @(posedge clock);
    chk({31'h0, fine_step}, 32'h1);
    rd(SWA_IDX_CAL_STAT);
    chk(d, 32'h0);
    rd(SWA_IDX_MAP_MID);
    chk(d, 32'h0);
    rd(SWA_IDX_MAP_LOW);
    chk(d, 32'h01);
    wr(SWA_IDX_CAL_SETUP, 32'h1);
    for (int i = 0; i < 6; i++) begin
      tgt0 <= rows[i].t0;
      tgt1 <= rows[i].t1;
      wr(SWA_IDX_CAL_GO, 32'h0);
      wr(SWA_IDX_CAL_GO, 32'h1);
      poll();
      chk(d, {7'h0, rows[i].res, 8'h03});
      chk({15'h0, delay}, {15'h0, rows[i].res});
    end
    for (int c = 0; c < 16; c += 5) begin
      wr(SWA_IDX_CLK_CTRL, 32'h10 | 32'(c));
      @(posedge clock);
      chk({28'h0, choice}, 32'(c));
      repeat (12) @(posedge clock);
      // capture shows the chosen tap as sampled one edge earlier
      sp = sysref;
      @(posedge clock);
      chk({31'h0, cap}, {31'h0, sp ? tap_pat[c] : ~tap_pat[c]});
    end
    wr(SWA_IDX_CLK_CTRL, 32'h10);
    rd(8'h31);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'hC00 | ba(SWA_IDX_DELAY), 32'h1FFFF);
    chk({31'h0, e}, 32'h1);
    rd(SWA_IDX_DELAY);
    chk(d, {15'h0, rows[5].res});
    // abort mid-search: busy seen, then idle with finished low
    tgt0 <= 9'h100;
    tgt1 <= 9'h100;
    wr(SWA_IDX_CAL_GO, 32'h0);
    wr(SWA_IDX_CAL_GO, 32'h1);
    repeat (60) @(posedge clock);
    rd(SWA_IDX_CAL_STAT);
    chk({29'h0, d[2:0]}, 32'h6);
    wr(SWA_IDX_CAL_GO, 32'h0);
    rd(SWA_IDX_CAL_STAT);
    chk({29'h0, d[2:0]}, 32'h2);
    wr(SWA_IDX_DELAY, 32'h11234);
    @(posedge clock);
    chk({15'h0, delay}, 32'h11234);
    rd(SWA_IDX_DELAY);
    chk(d, 32'h11234);
    // mid-run reset returns every control to its reset value
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({10'h0, fine_step, choice, delay}, 32'h0);
    rd(SWA_IDX_DELAY);
    chk(d, 32'h0);
    rd(SWA_IDX_CAL_STAT);
    chk(d, 32'h0);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
